//--- src/fpes_dev.sv
// Summary of operation
// - Unlock cycles ignore address bits 16 and up
// - Status is returned by asynchronous and burst reads alike
// - Host reads status twice before deciding
// - Polling bit reads inverted data while busy
// - Toggle bits flip per asynchronous status read, busy only
// - 8/16-word bursts wrap inside their group
// - Crossing a 128-word boundary, or starting at address 0, may add burst wait
// - No boundary wait at 66 MHz or below
// - Each inserted wait shows on ready output
// - Write may follow read with zero latency
// - Protected program: no change, toggle 20 us
// - Sector protection toggles busy for 20 us
// - Erase first programs region to 00h
// - Other banks readable while one is busy
// - Up to 32 words buffered, programmed together
// - Program uses two or four bus writes
// - Sector erase within 3.5 s, 8k within 2 s
module fpes_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(D);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fpes_fifo_s;
  fpes_fifo_s q, n;
  logic [W-1:0] mem [D];
  logic push, pop;
  assign in_ready = q.cnt != (PW+1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data = mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Pointers wrap naturally, so D must be a power of two
  always_comb begin
    n = q;
    if (push) n.wp = q.wp + 1'b1;
    if (pop) n.rp = q.rp + 1'b1;
    n.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (flush) n = '0;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else q <= n;
  end
  always_ff @(posedge mclk) begin
    if (push) mem[q.wp] <= in_data;
  end
endmodule // fpes_fifo

module fpes_dev
  import fpes_pkg::*;
#(
  parameter int unsigned WPROG_P = WPROG_CYC,
  parameter int unsigned BPROG_P = BPROG_CYC,
  parameter int unsigned ERS_P = ERS_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Flash bus
  fpes_bus_if.dev bus,
  // Read mode settings
  input wire logic sync_read_en,
  input wire logic [1:0] wrap_mode,
  input wire logic clk_above_66,
  // Status
  output logic dev_busy
);
  localparam int FW = MEM_AW + DW;
  typedef enum logic [4:0] {
    S_RD, S_U1, S_U2, S_PG, S_E1, S_E2, S_E3, S_BC, S_BL, S_BF,
    S_PR, S_BX, S_WP, S_TG, S_WB, S_EP, S_EW, S_EF
  } fpes_dst_e;
  typedef struct packed {
    fpes_dst_e st;
    logic byp;
    logic [AW-1:0] la;
    logic [MEM_AW-1:0] pa;
    logic [MEM_AW-1:0] idx;
    logic [MEM_AW-1:0] lim;
    logic [DW-1:0] pd;
    logic [31:0] tmr;
    logic busy;
    logic all;
    logic ers;
    logic [1:0] bank;
    logic tog;
    logic oen_q;
    logic [7:0] prot;
    logic [4:0] bcnt;
    logic bact;
    logic [3:0] bw;
    logic [AW-1:0] ba;
    logic rdy;
    logic [DW-1:0] dout;
    logic doe;
  } fpes_dev_s;
  fpes_dev_s q, n;
  logic [DW-1:0] mem [2**MEM_AW];
  logic mw, mfill;
  logic [MEM_AW-1:0] mwa;
  logic [DW-1:0] mwd;
  logic f_push, f_rdy, f_val, f_pop, f_flush;
  logic [FW-1:0] f_out;
  logic wr, rd, av;
  logic [15:0] a16;
  logic [AW-1:0] nba;

  function automatic logic hit(input logic [AW-1:0] a);
    hit = q.busy && (q.all || q.bank == a[MEM_AW-1:MEM_AW-2]);
  endfunction

  function automatic logic [DW-1:0] rd_word(input logic [AW-1:0] a);
    if (hit(a))
      rd_word = {8'h00, ~q.pd[7], q.tog, 3'h0, q.ers & q.tog, 2'h0};
    else
      rd_word = mem[a[MEM_AW-1:0]];
  endfunction

  function automatic logic is_prot(input logic [MEM_AW-1:0] a);
    is_prot = q.prot[a[MEM_AW-1:SEC_AW]];
  endfunction

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] a,
                                        input logic [1:0] m);
    case (m)
      BURST_W8: nxt = {a[AW-1:3], a[2:0] + 3'h1};
      BURST_W16: nxt = {a[AW-1:4], a[3:0] + 4'h1};
      default: nxt = a + 1'b1;
    endcase
  endfunction

  fpes_fifo #(.W(FW), .D(BUF_WORDS)) u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .flush(f_flush),
    .in_valid(f_push),
    .in_ready(f_rdy),
    .in_data({q.la[MEM_AW-1:0], bus.adq_h}),
    .out_valid(f_val),
    .out_ready(f_pop),
    .out_data(f_out)
  );

  assign bus.adq_d = q.dout;
  assign bus.adq_d_oe = q.doe;
  assign bus.rdy = q.rdy;
  assign dev_busy = q.busy;
  assign av = !bus.ce_n && !bus.address_valid_strobe_n;
  assign wr = !bus.ce_n && !bus.we_n && bus.address_valid_strobe_n;
  assign rd = !bus.ce_n && !bus.oe_n && bus.we_n;
  assign a16 = q.la[15:0];
  assign nba = nxt(q.ba, wrap_mode);

  always_comb begin
    n = q;
    mw = 1'b0;
    mfill = 1'b0;
    mwa = q.idx;
    mwd = PRE_WORD;
    f_push = 1'b0;
    f_pop = 1'b0;
    f_flush = 1'b0;
    n.oen_q = bus.oe_n;
    // Read side: served in any state, so writes may follow at once
    if (av) begin
      n.la = {bus.addr_hi, bus.adq_h};
      if (sync_read_en) begin
        n.bact = 1'b1;
        n.ba = {bus.addr_hi, bus.adq_h};
        n.bw = BURST_LAT - 4'h1;
        if (clk_above_66 && {bus.addr_hi, bus.adq_h} == '0)
          n.bw = BURST_LAT - 4'h1 + BND_WAIT;
        n.rdy = 1'b0;
      end
    end else if (rd && sync_read_en && q.bact) begin
      n.doe = 1'b1;
      if (q.bw != 4'h0) begin
        n.bw = q.bw - 4'h1;
        n.rdy = 1'b0;
      end else begin
        n.dout = rd_word(q.ba);
        n.rdy = 1'b1;
        n.ba = nba;
        if (clk_above_66 && nba[6:0] == 7'h00)
          n.bw = BND_WAIT;
      end
    end else if (rd && !sync_read_en) begin
      n.doe = 1'b1;
      n.dout = rd_word(q.la);
      if (q.oen_q && hit(q.la))
        n.tog = ~q.tog;
    end else begin
      n.doe = 1'b0;
    end
    if (bus.ce_n) begin
      n.bact = 1'b0;
      n.rdy = 1'b1;
    end
    // Command decoder and embedded operations
    case (q.st)
      S_RD: if (wr) begin
        if (q.byp && bus.adq_h == C_PROG) n.st = S_PG;
        else if (q.byp && bus.adq_h == C_BYPX) n.st = S_BX;
        else if (a16 == ULK_A1 && bus.adq_h == C_AA) n.st = S_U1;
      end
      S_U1: if (wr) begin
        n.st = (a16 == ULK_A2 && bus.adq_h == C_55) ? S_U2 : S_RD;
      end
      S_U2: if (wr) begin
        n.st = S_RD;
        n.pa = q.la[MEM_AW-1:0];
        if (bus.adq_h == C_WBUF) n.st = S_BC;
        else if (a16 == ULK_A1) begin
          case (bus.adq_h)
            C_PROG: n.st = S_PG;
            C_ERS: n.st = S_E1;
            C_BYP: n.byp = 1'b1;
            C_PROT: n.st = S_PR;
            default: n.st = S_RD;
          endcase
        end
      end
      S_PG: if (wr) begin
        n.pa = q.la[MEM_AW-1:0];
        n.pd = bus.adq_h;
        n.busy = 1'b1;
        n.bank = q.la[MEM_AW-1:MEM_AW-2];
        n.st = S_WP;
        n.tmr = WPROG_P - 1;
        if (is_prot(q.la[MEM_AW-1:0])) begin
          n.st = S_TG;
          n.tmr = PSP_CYC - 1;
        end
      end
      S_E1: if (wr) begin
        n.st = (a16 == ULK_A1 && bus.adq_h == C_AA) ? S_E2 : S_RD;
      end
      S_E2: if (wr) begin
        n.st = (a16 == ULK_A2 && bus.adq_h == C_55) ? S_E3 : S_RD;
      end
      S_E3: if (wr) begin
        n.st = S_RD;
        n.pd = ERASED;
        n.bank = q.la[MEM_AW-1:MEM_AW-2];
        if (bus.adq_h == C_SEC) begin
          n.pa = {q.la[MEM_AW-1:SEC_AW], {SEC_AW{1'b0}}};
          n.lim = {q.la[MEM_AW-1:SEC_AW], {SEC_AW{1'b1}}};
          n.busy = 1'b1;
          n.ers = 1'b1;
          n.st = S_EP;
          if (is_prot(q.la[MEM_AW-1:0])) begin
            n.st = S_TG;
            n.tmr = PSP_CYC - 1;
          end
        end else if (bus.adq_h == C_CHIP && a16 == ULK_A1) begin
          n.pa = '0;
          n.lim = '1;
          n.busy = 1'b1;
          n.all = 1'b1;
          n.ers = 1'b1;
          n.st = S_EP;
        end
        n.idx = n.pa;
      end
      S_BC: if (wr) begin
        n.bcnt = bus.adq_h[4:0];
        n.st = (bus.adq_h[15:5] == '0) ? S_BL : S_RD;
      end
      S_BL: if (wr) begin
        // Words outside the sector or past a full buffer abort the load
        if (f_rdy && q.la[MEM_AW-1:SEC_AW] == q.pa[MEM_AW-1:SEC_AW]) begin
          f_push = 1'b1;
          n.pd = bus.adq_h;
          n.bcnt = q.bcnt - 5'h1;
          if (q.bcnt == 5'h0) n.st = S_BF;
        end else begin
          f_flush = 1'b1;
          n.st = S_RD;
        end
      end
      S_BF: if (wr) begin
        n.bank = q.pa[MEM_AW-1:MEM_AW-2];
        n.busy = bus.adq_h == C_WCONF;
        n.st = (bus.adq_h == C_WCONF) ? S_WB : S_RD;
        n.tmr = BPROG_P - 1;
        f_flush = bus.adq_h != C_WCONF;
        if (bus.adq_h == C_WCONF && is_prot(q.pa)) begin
          n.st = S_TG;
          n.tmr = PSP_CYC - 1;
          f_flush = 1'b1;
        end
      end
      S_PR: if (wr) begin
        n.prot[q.la[MEM_AW-1:SEC_AW]] = bus.adq_h[0];
        n.pd = PRE_WORD;
        n.busy = 1'b1;
        n.bank = q.la[MEM_AW-1:MEM_AW-2];
        n.tmr = ASP_CYC - 1;
        n.st = S_TG;
      end
      S_BX: if (wr) begin
        if (bus.adq_h == C_BYPX2) n.byp = 1'b0;
        n.st = S_RD;
      end
      S_WP, S_TG: begin
        if (q.tmr != '0) n.tmr = q.tmr - 1;
        else begin
          mw = q.st == S_WP;
          mwa = q.pa;
          mwd = q.pd;
          n.busy = 1'b0;
          n.st = S_RD;
        end
      end
      S_WB: begin
        f_pop = 1'b1;
        mw = f_val;
        mwa = f_out[FW-1:DW];
        mwd = f_out[DW-1:0];
        if (q.tmr != '0) n.tmr = q.tmr - 1;
        else if (!f_val) begin
          n.busy = 1'b0;
          n.st = S_RD;
        end
      end
      S_EP: begin
        mw = !is_prot(q.idx);
        n.idx = q.idx + 1'b1;
        if (q.idx == q.lim) begin
          n.tmr = ERS_P - 1;
          n.st = S_EW;
        end
      end
      S_EW: begin
        n.idx = q.pa;
        if (q.tmr != '0) n.tmr = q.tmr - 1;
        else n.st = S_EF;
      end
      S_EF: begin
        mw = !is_prot(q.idx);
        mfill = 1'b1;
        n.idx = q.idx + 1'b1;
        if (q.idx == q.lim) begin
          n.busy = 1'b0;
          n.all = 1'b0;
          n.ers = 1'b0;
          n.st = S_RD;
        end
      end
      default: n.st = S_RD;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= S_RD;
      q.oen_q <= 1'b1;
      q.rdy <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Programming only clears bits; the erase fill sets them back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**MEM_AW; i++) mem[i] <= ERASED;
    end else if (mw) begin
      mem[mwa] <= mfill ? ERASED : (mem[mwa] & mwd);
    end
  end
endmodule // fpes_dev

//--- src/fpes_pkg.sv
package fpes_pkg;
  localparam int AW = 22;
  localparam int DW = 16;
  localparam int MEM_AW = 9;
  localparam int SEC_AW = 6;
  localparam int BUF_WORDS = 32;
  localparam logic [15:0] ULK_A1 = 16'h0555;
  localparam logic [15:0] ULK_A2 = 16'h02AA;
  localparam logic [15:0] C_AA = 16'h00AA;
  localparam logic [15:0] C_55 = 16'h0055;
  localparam logic [15:0] C_PROG = 16'h00A0;
  localparam logic [15:0] C_ERS = 16'h0080;
  localparam logic [15:0] C_SEC = 16'h0030;
  localparam logic [15:0] C_CHIP = 16'h0010;
  localparam logic [15:0] C_WBUF = 16'h0025;
  localparam logic [15:0] C_WCONF = 16'h0029;
  localparam logic [15:0] C_BYP = 16'h0020;
  localparam logic [15:0] C_BYPX = 16'h0090;
  localparam logic [15:0] C_BYPX2 = 16'h0000;
  localparam logic [15:0] C_PROT = 16'h0060;
  localparam logic [15:0] PRE_WORD = 16'h0000;
  localparam logic [15:0] ERASED = 16'hFFFF;
  localparam int CLK_MHZ = 100;
  localparam int T_PSP_US = 20;
  localparam int T_ASP_US = 20;
  localparam int unsigned PSP_CYC = T_PSP_US * CLK_MHZ;
  localparam int unsigned ASP_CYC = T_ASP_US * CLK_MHZ;
  localparam int T_WPROG_US = 170;
  localparam int unsigned WPROG_CYC = T_WPROG_US * CLK_MHZ;
  localparam int T_BPROG_US = 450;
  localparam int unsigned BPROG_CYC = T_BPROG_US * CLK_MHZ;
  localparam int T_ERS_TYP_MS = 800;
  localparam int T_ERS_MAX_MS = 3500;
  localparam int T_ERS8_MAX_MS = 2000;
  localparam int unsigned ERS_CYC = T_ERS_TYP_MS * CLK_MHZ * 1000;
  localparam int unsigned ERS_MAX_CYC = T_ERS_MAX_MS * CLK_MHZ * 1000;
  localparam logic [3:0] BURST_LAT = 4'h5;
  localparam logic [3:0] BND_WAIT = 4'h2;
  localparam logic [1:0] BURST_CONT = 2'h0;
  localparam logic [1:0] BURST_W8 = 2'h1;
  localparam logic [1:0] BURST_W16 = 2'h2;
  typedef enum logic [2:0] {
    OP_WRITE, OP_READ, OP_PROG, OP_BPROG,
    OP_SERASE, OP_CERASE, OP_POLL, OP_BURST
  } fpes_op_e;
endpackage

//--- src/fpes_bus_if.sv
interface fpes_bus_if;
  import fpes_pkg::*;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic address_valid_strobe_n;
  logic [AW-1:16] addr_hi;
  logic [15:0] adq_h;
  logic adq_h_oe;
  logic [15:0] adq_d;
  logic adq_d_oe;
  logic rdy;
  // Resolved level of the shared address/data lines
  wire [15:0] adq = adq_h_oe ? adq_h : (adq_d_oe ? adq_d : 16'h0000);
  modport dev (
    input ce_n, oe_n, we_n, address_valid_strobe_n, addr_hi, adq_h,
    input adq_h_oe,
    output adq_d, adq_d_oe, rdy
  );
  modport host (
    output ce_n, oe_n, we_n, address_valid_strobe_n, addr_hi, adq_h,
    output adq_h_oe,
    input adq_d, adq_d_oe, rdy
  );
endinterface

//--- src/fpes_host.sv
module fpes_host
  import fpes_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Flash bus
  fpes_bus_if.host bus,
  // Request
  input wire logic req_valid,
  input wire fpes_op_e req_op,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_data,
  output logic req_ready,
  // Response
  output logic rsp_valid,
  output logic [DW-1:0] rsp_data
);
  typedef enum logic [2:0] {
    H_IDLE, H_AV, H_WE, H_OE, H_CAP, H_RE, H_GAP
  } fpes_hst_e;
  typedef struct packed {
    fpes_hst_e st;
    fpes_op_e op;
    logic [AW-1:0] a;
    logic [DW-1:0] d;
    logic [2:0] s;
    logic [4:0] n;
    logic [7:6] pv;
    logic hp;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic avd_n;
    logic [AW-1:16] ahi;
    logic [15:0] adq;
    logic hoe;
    logic req_ready;
    logic rsp_valid;
    logic [DW-1:0] rsp_data;
  } fpes_host_s;
  fpes_host_s q, n;
  logic [AW+DW-1:0] sw;
  logic is_wr;

  // Unlock addresses keep the caller's upper bits, which must not matter
  function automatic logic [AW+DW-1:0] seq(input fpes_op_e op,
      input logic [2:0] s, input logic [AW-1:0] a,
      input logic [DW-1:0] d);
    logic [AW-1:0] u1;
    logic [AW-1:0] u2;
    u1 = {a[AW-1:16], ULK_A1};
    u2 = {a[AW-1:16], ULK_A2};
    seq = {a, d};
    case (op)
      OP_PROG: case (s)
        3'd0: seq = {u1, C_AA};
        3'd1: seq = {u2, C_55};
        3'd2: seq = {u1, C_PROG};
        default: seq = {a, d};
      endcase
      OP_BPROG: if (s == 3'd0) seq = {u1, C_PROG};
      OP_SERASE, OP_CERASE: case (s)
        3'd0, 3'd3: seq = {u1, C_AA};
        3'd1, 3'd4: seq = {u2, C_55};
        3'd2: seq = {u1, C_ERS};
        default: seq = (op == OP_CERASE) ? {u1, C_CHIP} : {a, C_SEC};
      endcase
      default: seq = {a, d};
    endcase
  endfunction

  function automatic logic [2:0] last(input fpes_op_e op);
    case (op)
      OP_PROG: last = 3'd3;
      OP_BPROG: last = 3'd1;
      OP_SERASE, OP_CERASE: last = 3'd5;
      default: last = 3'd0;
    endcase
  endfunction

  assign bus.ce_n = q.ce_n;
  assign bus.oe_n = q.oe_n;
  assign bus.we_n = q.we_n;
  assign bus.address_valid_strobe_n = q.avd_n;
  assign bus.addr_hi = q.ahi;
  assign bus.adq_h = q.adq;
  assign bus.adq_h_oe = q.hoe;
  assign req_ready = q.req_ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;
  assign is_wr = q.op != OP_READ && q.op != OP_POLL && q.op != OP_BURST;

  always_comb begin
    n = q;
    n.rsp_valid = 1'b0;
    sw = seq(q.op, q.s, q.a, q.d);
    case (q.st)
      H_IDLE: if (req_valid && q.req_ready) begin
        n.op = req_op;
        n.a = req_addr;
        n.d = req_data;
        n.s = 3'd0;
        n.n = req_data[4:0];
        n.hp = 1'b0;
        n.req_ready = 1'b0;
        sw = seq(req_op, 3'd0, req_addr, req_data);
        n.st = H_AV;
        n.ce_n = 1'b0;
        n.avd_n = 1'b0;
        n.hoe = 1'b1;
        n.ahi = sw[AW+DW-1:DW+16];
        n.adq = sw[DW+15:DW];
      end
      H_AV: begin
        n.avd_n = 1'b1;
        if (is_wr) begin
          n.we_n = 1'b0;
          n.adq = sw[DW-1:0];
          n.st = H_WE;
        end else begin
          n.hoe = 1'b0;
          n.oe_n = 1'b0;
          n.st = H_OE;
        end
      end
      H_WE: begin
        n.we_n = 1'b1;
        if (q.s == last(q.op)) begin
          n.rsp_valid = 1'b1;
          n.rsp_data = '0;
          n.st = H_GAP;
        end else begin
          n.s = q.s + 3'd1;
          sw = seq(q.op, q.s + 3'd1, q.a, q.d);
          n.avd_n = 1'b0;
          n.ahi = sw[AW+DW-1:DW+16];
          n.adq = sw[DW+15:DW];
          n.st = H_AV;
        end
      end
      H_OE: n.st = H_CAP;
      H_CAP: if (bus.adq_d_oe && (bus.rdy || q.op != OP_BURST)) begin
        if (q.op == OP_POLL && !(q.hp && bus.adq_d[7:6] == q.pv)) begin
          n.pv = bus.adq_d[7:6];
          n.hp = 1'b1;
          n.oe_n = 1'b1;
          n.st = H_RE;
        end else begin
          n.rsp_valid = 1'b1;
          n.rsp_data = bus.adq_d;
          n.n = q.n - 5'd1;
          if (q.op != OP_BURST || q.n == 5'd0) n.st = H_GAP;
        end
      end
      H_RE: begin
        n.oe_n = 1'b0;
        n.st = H_OE;
      end
      H_GAP: begin
        n.req_ready = 1'b1;
        n.st = H_IDLE;
      end
      default: n.st = H_IDLE;
    endcase
    if (n.st == H_GAP) begin
      n.ce_n = 1'b1;
      n.oe_n = 1'b1;
      n.we_n = 1'b1;
      n.avd_n = 1'b1;
      n.hoe = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= H_IDLE;
      q.op <= OP_READ;
      q.ce_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.we_n <= 1'b1;
      q.avd_n <= 1'b1;
      q.req_ready <= 1'b1;
    end else begin
      q <= n;
    end
  end
endmodule // fpes_host

//--- dv/fpes_asserts.sv
module fpes_asserts
  import fpes_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Flash bus
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic address_valid_strobe_n,
  input wire logic adq_h_oe,
  input wire logic adq_d_oe,
  input wire logic rdy,
  // Read mode
  input wire logic sync_read_en,
  input wire logic clk_above_66
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_no_contention: assert property (!(adq_h_oe && adq_d_oe))
    else $error("both ends drive the shared lines");
  a_async_answer: assert property (
    (!sync_read_en && !ce_n && !oe_n && we_n) |=> adq_d_oe)
    else $error("asynchronous read not answered next cycle");
  a_oe_release: assert property ((oe_n ##1 oe_n) |-> !adq_d_oe)
    else $error("device drives with output enable off");
  a_ce_release: assert property (ce_n |=> !adq_d_oe)
    else $error("device drives while deselected");
  a_idle_ready: assert property ((ce_n ##1 ce_n) |-> rdy)
    else $error("ready low outside a burst");
  a_burst_wait: assert property (
    (sync_read_en && !ce_n && !address_valid_strobe_n) |=> !rdy)
    else $error("burst start not signalled as wait");
  a_word_ready: assert property (
    (sync_read_en && !ce_n && $rose(rdy)) |-> adq_d_oe)
    else $error("ready rose without a word");
  a_no_bnd_wait: assert property (
    (sync_read_en && !clk_above_66 && !ce_n && !oe_n && rdy &&
     address_valid_strobe_n) ##1 (!ce_n && !oe_n) |-> rdy)
    else $error("wait inserted at slow burst clock");
endmodule // fpes_asserts

//--- dv/fpes_tb.sv
module fpes_tb
  import fpes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n, sync_read_en, clk_above_66, dev_busy;
  logic req_valid, req_ready, rsp_valid;
  logic [1:0] wrap_mode;
  fpes_op_e req_op;
  logic [AW-1:0] req_addr;
  logic [DW-1:0] req_data, rsp_data;
  logic [DW-1:0] got [16];
  int mismatches, total_checks, cycles, lows;

  always #5 mclk = ~mclk;

  fpes_bus_if bus ();
  fpes_dev #(.WPROG_P(20), .BPROG_P(40), .ERS_P(50)) u_fpes_dev (
    .mclk(mclk), .rst_n(rst_n), .bus(bus.dev),
    .sync_read_en(sync_read_en), .wrap_mode(wrap_mode),
    .clk_above_66(clk_above_66), .dev_busy(dev_busy));
  fpes_host u_fpes_host (
    .mclk(mclk), .rst_n(rst_n), .bus(bus.host),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  fpes_asserts u_chk (
    .mclk(mclk), .rst_n(rst_n), .ce_n(bus.ce_n), .oe_n(bus.oe_n),
    .we_n(bus.we_n), .address_valid_strobe_n(bus.address_valid_strobe_n),
    .adq_h_oe(bus.adq_h_oe), .adq_d_oe(bus.adq_d_oe), .rdy(bus.rdy),
    .sync_read_en(sync_read_en), .clk_above_66(clk_above_66));

  task automatic conclude();
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Wait cycles counted on the falling edge, where ready has settled
  always @(negedge mclk) begin
    if (bus.rdy === 1'b0) lows <= lows + 1;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input fpes_op_e o, input logic [AW-1:0] a,
                      input logic [DW-1:0] d, input int cnt);
    int n;
    // Outputs judged at the falling edge, clear of the launching edge
    n = 0;
    do begin @(negedge mclk); n++; end
    while (req_ready !== 1'b1 && n < 50);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_data <= d;
    @(posedge mclk);
    req_valid <= 1'b0;
    for (int k = 0; k < cnt; k++) begin
      n = 0;
      do begin @(negedge mclk); n++; end
      while (rsp_valid !== 1'b1 && n < 6000);
      got[k] = rsp_data;
      chk("response", 1, n < 6000);
    end
    @(posedge mclk);
  endtask

  task automatic tog2(input string nm, input logic [AW-1:0] a,
                      input int b);
    logic [DW-1:0] s0;
    xfer(OP_READ, a, 16'h0000, 1);
    s0 = got[0];
    xfer(OP_READ, a, 16'h0000, 1);
    chk(nm, 1, s0[b] ^ got[0][b]);
  endtask

  task automatic busy_len(output int n);
    n = 0;
    while (dev_busy === 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic t_program();
    // Upper bits set in unlock cycles, then bypass two-cycle program
    logic [37:0] w [11] = '{{22'h3F0555, C_AA}, {22'h3F02AA, C_55},
      {22'h3F0555, C_PROG}, {22'h000020, 16'h00F0}, {22'h000555, C_AA},
      {22'h0002AA, C_55}, {22'h000555, C_BYP}, {22'h000555, C_PROG},
      {22'h000021, 16'h0F0F}, {22'h000555, C_BYPX}, {22'h000555, C_BYPX2}};
    xfer(OP_PROG, 22'h000010, 16'h1234, 1);
    tog2("prog_toggle", 22'h000010, 6);
    chk("poll_bit", 1, got[0][7]);
    xfer(OP_POLL, 22'h000010, 16'h0000, 1);
    chk("prog_data", 16'h1234, got[0]);
    xfer(OP_READ, 22'h000010, 16'h0000, 1);
    chk("settled", 16'h1234, got[0]);
    for (int i = 0; i < 11; i++) begin
      xfer(OP_WRITE, w[i][37:16], w[i][15:0], 1);
      if (i == 6) begin
        xfer(OP_BPROG, 22'h000022, 16'h3C3C, 1);
        xfer(OP_POLL, 22'h000022, 16'h0000, 1);
        chk("bypass_prog", 16'h3C3C, got[0]);
      end
      if (i == 3 || i == 8) begin
        xfer(OP_POLL, w[i][37:16], 16'h0000, 1);
        chk("word_prog", w[i][15:0], got[0]);
      end
    end
  endtask

  task automatic t_burst();
    int l0, d0;
    for (int i = 0; i < 16; i++) begin
      xfer(OP_PROG, 22'(64 + i), 16'(16'hA500 + i), 1);
      xfer(OP_POLL, 22'(64 + i), 16'h0000, 1);
    end
    sync_read_en <= 1'b1;
    wrap_mode <= BURST_W8;
    xfer(OP_BURST, 22'h000046, 16'h0007, 8);
    for (int k = 0; k < 8; k++)
      chk("wrap8", 16'hA500 + ((6 + k) % 8), got[k]);
    wrap_mode <= BURST_W16;
    xfer(OP_BURST, 22'h00004E, 16'h000F, 16);
    for (int k = 0; k < 16; k++)
      chk("wrap16", 16'hA500 + ((14 + k) % 16), got[k]);
    wrap_mode <= BURST_CONT;
    for (int s = 0; s < 2; s++) begin
      clk_above_66 <= 1'b0;
      l0 = lows;
      xfer(OP_BURST, s ? 22'h000000 : 22'h00007C, 16'h0007, 8);
      d0 = lows - l0;
      clk_above_66 <= 1'b1;
      l0 = lows;
      xfer(OP_BURST, s ? 22'h000000 : 22'h00007C, 16'h0007, 8);
      chk("bnd_wait", BND_WAIT, lows - l0 - d0);
    end
    sync_read_en <= 1'b0;
  endtask

  task automatic t_bank();
    xfer(OP_SERASE, 22'h000000, 16'h0000, 1);
    xfer(OP_READ, 22'h000100, 16'h0000, 1);
    chk("other_bank", ERASED, got[0]);
    chk("busy", 1, dev_busy);
    tog2("erase_toggle", 22'h000010, 2);
    xfer(OP_POLL, 22'h000010, 16'h0000, 1);
    chk("erased", ERASED, got[0]);
    xfer(OP_READ, 22'h000040, 16'h0000, 1);
    chk("kept", 16'hA500, got[0]);
  endtask

  task automatic t_protect();
    logic [37:0] p [4] = '{{22'h000555, C_AA}, {22'h0002AA, C_55},
      {22'h000555, C_PROT}, {22'h000000, 16'h0001}};
    int n;
    for (int i = 0; i < 4; i++)
      xfer(OP_WRITE, p[i][37:16], p[i][15:0], 1);
    tog2("prot_toggle", 22'h000000, 6);
    busy_len(n);
    chk("prot_time", 1, n > ASP_CYC - 100 && n <= ASP_CYC);
    xfer(OP_PROG, 22'h000005, 16'h0000, 1);
    tog2("psp_toggle", 22'h000005, 6);
    busy_len(n);
    chk("psp_time", 1, n > PSP_CYC - 100 && n <= PSP_CYC);
    xfer(OP_READ, 22'h000005, 16'h0000, 1);
    chk("unchanged", ERASED, got[0]);
  endtask

  task automatic t_buffer();
    // Full 32-word load into sector 2 fills the buffer exactly
    logic [37:0] p [4] = '{{22'h000555, C_AA}, {22'h0002AA, C_55},
      {22'h000080, C_WBUF}, {22'h000080, 16'h001F}};
    for (int i = 0; i < 4; i++)
      xfer(OP_WRITE, p[i][37:16], p[i][15:0], 1);
    for (int i = 0; i < BUF_WORDS; i++)
      xfer(OP_WRITE, 22'(128 + i), 16'(16'hC000 + i), 1);
    xfer(OP_WRITE, 22'h000080, C_WCONF, 1);
    chk("buf_busy", 1, dev_busy);
    xfer(OP_POLL, 22'h000080, 16'h0000, 1);
    chk("buf_done", 0, dev_busy);
    for (int i = 0; i < BUF_WORDS; i++) begin
      xfer(OP_READ, 22'(128 + i), 16'h0000, 1);
      chk("buf_data", 16'hC000 + i, got[0]);
    end
    xfer(OP_CERASE, 22'h000000, 16'h0000, 1);
    xfer(OP_POLL, 22'h000080, 16'h0000, 1);
    chk("chip_erased", ERASED, got[0]);
  endtask

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = OP_READ;
    req_addr = '0;
    req_data = '0;
    sync_read_en = 1'b0;
    wrap_mode = BURST_CONT;
    clk_above_66 = 1'b1;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    lows = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_program();
    t_burst();
    t_bank();
    t_protect();
    t_buffer();
    conclude();
  end
endmodule // fpes_tb
